// ==== include/dab_pkg.sv ====
// package: offsets, field positions, defaults and types for the register slice
package dab_pkg;

   // ---------------------------------------------------------------
   // register offsets (5-bit serial address)
   // ---------------------------------------------------------------
   localparam logic [4:0] OFS_DATA_CTRL   = 5'h02;
   localparam logic [4:0] OFS_POWER_DOWN  = 5'h03;
   localparam logic [4:0] OFS_MIX_MODE    = 5'h0a;
   localparam logic [4:0] OFS_AUX1_LOW    = 5'h0d;
   localparam logic [4:0] OFS_AUX1_HIGH   = 5'h0e;
   localparam logic [4:0] OFS_SCALE_LOW   = 5'h0f;
   localparam logic [4:0] OFS_SCALE_HIGH  = 5'h10;
   localparam logic [4:0] OFS_AUX2_LOW    = 5'h11;
   localparam logic [4:0] OFS_AUX2_HIGH   = 5'h12;
   localparam logic [4:0] OFS_TEST_CTRL   = 5'h1a;
   localparam logic [4:0] OFS_RES_A_LOW   = 5'h1b;
   localparam logic [4:0] OFS_RES_A_HIGH  = 5'h1c;
   localparam logic [4:0] OFS_RES_B_LOW   = 5'h1d;
   localparam logic [4:0] OFS_RES_B_HIGH  = 5'h1e;
   localparam logic [4:0] OFS_CHIP_ID     = 5'h1f;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PIN_SELECT_BIT  = 7;
   localparam int SINK_SELECT_BIT = 6;
   localparam int RUN_BIT         = 7;
   localparam int CAPTURE_BIT     = 6;
   localparam int CLEAR_BIT       = 5;
   localparam int FORMAT_BIT      = 7;
   localparam int READ_FLAG_BIT   = 7;

   // ---------------------------------------------------------------
   // values after reset, forced values and the signature polynomial
   // ---------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [9:0] RESET_WORD      = 10'h000;
   localparam logic [15:0] RESET_RESULT   = 16'h0000;
   localparam logic [7:0] PIN_MIX_VALUE   = 8'h05;
   localparam logic [7:0] PIN_POWER_VALUE = 8'hff;
   localparam logic [15:0] SIG_POLY       = 16'h1021;

   // ---------------------------------------------------------------
   // serial frame counts
   // ---------------------------------------------------------------
   localparam logic [3:0] LAST_INSTR_BIT  = 4'h7;
   localparam logic [3:0] LAST_FRAME_BIT  = 4'hf;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       pin_select;
      logic       sink_select;
      logic [9:0] word;
   } dab_aux_cfg_s;

   typedef enum logic [1:0] {
      SER_IDLE  = 2'b00,
      SER_INSTR = 2'b01,
      SER_DATA  = 2'b10,
      SER_HOLD  = 2'b11
   } dab_ser_state_e;

endpackage : dab_pkg

// ==== rtl/dab_regs.sv ====
// module: control register slice with serial access, self-test and pin mode
`timescale 1ns/1ps

// Behaviour
// - first aux current word is 10 bits: 0x0d low byte, 0x0e bits 1:0.
// - aux current words map linearly, 0x3ff full, 0x200 half, 0x000 none.
// - 0x0e bit 7 picks first aux pin: 0 positive, 1 negative.
// - 0x0e bit 6 sets first aux direction: 0 source, 1 sink.
// - second converter scale word: 0x0f low byte, 0x10 bits 1:0.
// - second aux current word: 0x11 low byte, 0x12 bits 1:0.
// - 0x12 bit 7 picks second aux pin: 0 positive, 1 negative.
// - 0x12 bit 6 sets second aux direction: 0 source, 1 sink.
// - self-test control bit 7 enables and runs the self-test.
// - writing control bit 6 copies engine values into readable results.
// - writing control bit 5 resets engines and clears both results.
// - first result: low byte at 0x1b, high byte at 0x1c.
// - second result: low byte at 0x1d, high byte at 0x1e.
// - 0x1f is read-only, bits 7:4 give the chip revision.
// - 0x1f bits 3:0 give the device type code.
// - a high reset pin returns every control bit to its default, except the format, mix-mode and power-down fields.
// - serial port works only after reset pin returns low.
// - reset pin held high means pin mode; serial pins become inputs.
// - in pin mode the data-format bit follows the serial data pin.
// - in pin mode a high chip select forces mix mode to 0x05.
// - in pin mode a high data-out pin forces power-down to 0xff.
// - defined bits read back the last written value unless read-only.
module dab_regs #(
   parameter logic [3:0] CHIP_VERSION = 4'h1,  // arbitrary value
   parameter logic [3:0] CHIP_DEVICE  = 4'h2   // arbitrary value
) (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   // device pins (asynchronous)
   input  wire logic                  reset_pin,
   input  wire logic                  spi_clk,
   input  wire logic                  chip_select_low,
   input  wire logic                  serial_data_in,
   input  wire logic                  serial_data_out_in,
   output logic                       serial_data_out,
   output logic                       serial_data_out_oe,
   // self-test sample words (sys_clk domain)
   input  wire logic [15:0]           self_test_word_a,
   input  wire logic [15:0]           self_test_word_b,
   // configuration outputs
   output dab_pkg::dab_aux_cfg_s      aux_current_word_one,
   output dab_pkg::dab_aux_cfg_s      aux_current_word_two,
   output logic                       aux_one_positive_out,
   output logic                       aux_one_negative_out,
   output logic                       aux_two_positive_out,
   output logic                       aux_two_negative_out,
   output logic [9:0]                 second_converter_scale_word,
   output logic                       data_format,
   output logic [7:0]                 mix_mode,
   output logic [7:0]                 power_down,
   output logic                       self_test_run,
   output logic                       pin_mode
);
   import dab_pkg::*;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // index: 0 reset pin, 1 clock, 2 chip select, 3 data in, 4 data out
   logic [4:0]     pin_meta_reg;
   logic [4:0]     pin_sync_reg;
   logic           sclk_prev_reg;
   logic           sclk_rise;
   logic           sclk_fall;
   logic           ctl_reset;

   always_ff @(posedge sys_clk) begin
      // chip select idles high: a zero here would open a false frame
      if (sys_rst) begin
         pin_meta_reg  <= 5'h04;
         pin_sync_reg  <= 5'h04;
         sclk_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg  <= {serial_data_out_in, serial_data_in,
                           chip_select_low, spi_clk, reset_pin};
         pin_sync_reg  <= pin_meta_reg;
         sclk_prev_reg <= pin_sync_reg[1];
      end
   end

   assign sclk_rise = pin_sync_reg[1] & ~sclk_prev_reg;
   assign sclk_fall = ~pin_sync_reg[1] & sclk_prev_reg;
   assign ctl_reset = sys_rst | pin_sync_reg[0];

   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         pin_mode <= 1'b0;
      else
         pin_mode <= pin_sync_reg[0];
   end

   // ---------------------------------------------------------------
   // serial frame engine
   // ---------------------------------------------------------------
   // frame: 8-bit instruction (bit 7 read, bits 4:0 address), 8 data
   // bits, msb first; the pins are oversampled, so the serial clock must
   // stay below an eighth of sys_clk
   dab_ser_state_e ser_state_reg;
   logic [3:0]     bit_cnt_reg;
   logic [7:0]     shift_in_reg;
   logic [7:0]     instr_reg;
   logic [7:0]     shift_out_reg;
   logic           wr_en_reg;
   logic [7:0]     wr_data_reg;
   logic [7:0]     read_data;
   logic           is_read;

   assign is_read = instr_reg[READ_FLAG_BIT];

   always_ff @(posedge sys_clk) begin
      if (ctl_reset || pin_mode) begin
         ser_state_reg <= SER_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_in_reg  <= RESET_BYTE;
         instr_reg     <= RESET_BYTE;
         wr_en_reg     <= 1'b0;
         wr_data_reg   <= RESET_BYTE;
      end else begin
         wr_en_reg <= 1'b0;
         case (ser_state_reg)
            SER_IDLE: begin
               bit_cnt_reg <= 4'h0;
               if (!pin_sync_reg[2])
                  ser_state_reg <= SER_INSTR;
            end
            SER_INSTR, SER_DATA: begin
               if (pin_sync_reg[2]) begin
                  // chip select released mid-frame: drop it
                  ser_state_reg <= SER_IDLE;
               end else if (sclk_rise) begin
                  shift_in_reg <= {shift_in_reg[6:0], pin_sync_reg[3]};
                  bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == LAST_INSTR_BIT) begin
                     instr_reg     <= {shift_in_reg[6:0], pin_sync_reg[3]};
                     ser_state_reg <= SER_DATA;
                  end else if (bit_cnt_reg == LAST_FRAME_BIT) begin
                     wr_data_reg   <= {shift_in_reg[6:0], pin_sync_reg[3]};
                     wr_en_reg     <= ~is_read;
                     ser_state_reg <= SER_HOLD;
                  end
               end
            end
            SER_HOLD: begin
               if (pin_sync_reg[2])
                  ser_state_reg <= SER_IDLE;
            end
            default: ser_state_reg <= SER_IDLE;
         endcase
      end
   end

   // read data is shifted out on falling clock edges of the data phase
   always_ff @(posedge sys_clk) begin
      if (ctl_reset || pin_mode) begin
         shift_out_reg      <= RESET_BYTE;
         serial_data_out    <= 1'b0;
         serial_data_out_oe <= 1'b0;
      end else begin
         serial_data_out_oe <= (ser_state_reg == SER_DATA) & is_read &
                               ~pin_sync_reg[2];
         if (ser_state_reg == SER_INSTR && sclk_rise &&
             bit_cnt_reg == LAST_INSTR_BIT)
            shift_out_reg <= read_data;
         else if (ser_state_reg == SER_DATA && sclk_fall) begin
            serial_data_out <= shift_out_reg[7];
            shift_out_reg   <= {shift_out_reg[6:0], 1'b0};
         end
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic [7:0]  aux1_low_reg;
   logic [7:0]  aux1_high_reg;
   logic [7:0]  scale_low_reg;
   logic [7:0]  scale_high_reg;
   logic [7:0]  aux2_low_reg;
   logic [7:0]  aux2_high_reg;
   logic [7:0]  test_ctrl_reg;
   logic [4:0]  wr_addr;
   logic        wr_test;

   assign wr_addr = instr_reg[4:0];
   assign wr_test = wr_en_reg && wr_addr == OFS_TEST_CTRL;

   always_ff @(posedge sys_clk) begin
      if (ctl_reset) begin
         aux1_low_reg   <= RESET_BYTE;
         aux1_high_reg  <= RESET_BYTE;
         scale_low_reg  <= RESET_BYTE;
         scale_high_reg <= RESET_BYTE;
         aux2_low_reg   <= RESET_BYTE;
         aux2_high_reg  <= RESET_BYTE;
         test_ctrl_reg  <= RESET_BYTE;
      end else if (wr_en_reg) begin
         // undefined bits are not stored and read as zero
         case (wr_addr)
            OFS_AUX1_LOW:   aux1_low_reg   <= wr_data_reg;
            OFS_AUX1_HIGH:  aux1_high_reg  <= wr_data_reg & 8'hc3;
            OFS_SCALE_LOW:  scale_low_reg  <= wr_data_reg;
            OFS_SCALE_HIGH: scale_high_reg <= wr_data_reg & 8'h03;
            OFS_AUX2_LOW:   aux2_low_reg   <= wr_data_reg;
            OFS_AUX2_HIGH:  aux2_high_reg  <= wr_data_reg & 8'hc3;
            OFS_TEST_CTRL:  test_ctrl_reg  <= wr_data_reg & 8'he0;
            default: ;
         endcase
      end
   end

   // fields forced by pin mode; serial writes reach them outside it
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         data_format <= 1'b0;
         mix_mode    <= RESET_BYTE;
         power_down  <= RESET_BYTE;
      end else if (pin_sync_reg[0]) begin
         data_format <= pin_sync_reg[3];
         mix_mode    <= pin_sync_reg[2] ? PIN_MIX_VALUE : RESET_BYTE;
         power_down  <= pin_sync_reg[4] ? PIN_POWER_VALUE : RESET_BYTE;
      end else if (wr_en_reg) begin
         if (wr_addr == OFS_DATA_CTRL)
            data_format <= wr_data_reg[FORMAT_BIT];
         if (wr_addr == OFS_MIX_MODE)
            mix_mode <= wr_data_reg & 8'h0f;
         if (wr_addr == OFS_POWER_DOWN)
            power_down <= wr_data_reg;
      end
   end

   // ---------------------------------------------------------------
   // self-test engines
   // ---------------------------------------------------------------
   logic [15:0] sig_a_reg;
   logic [15:0] sig_b_reg;
   logic [15:0] result_a_reg;
   logic [15:0] result_b_reg;
   logic        test_clear;
   logic        test_capture;

   // signature step shared by both engines
   function automatic logic [15:0] sig_step(input logic [15:0] sig,
                                            input logic [15:0] word);
      logic [15:0] nxt;
      nxt = {sig[14:0], 1'b0} ^ word;
      if (sig[15])
         nxt = nxt ^ SIG_POLY;
      return nxt;
   endfunction : sig_step

   assign test_clear   = wr_test & wr_data_reg[CLEAR_BIT];
   assign test_capture = wr_test & wr_data_reg[CAPTURE_BIT];

   always_ff @(posedge sys_clk) begin
      if (ctl_reset || test_clear) begin
         sig_a_reg <= RESET_RESULT;
         sig_b_reg <= RESET_RESULT;
      end else if (test_ctrl_reg[RUN_BIT]) begin
         sig_a_reg <= sig_step(sig_a_reg, self_test_word_a);
         sig_b_reg <= sig_step(sig_b_reg, self_test_word_b);
      end
   end

   // clear wins when capture and clear are written together
   always_ff @(posedge sys_clk) begin
      if (ctl_reset || test_clear) begin
         result_a_reg <= RESET_RESULT;
         result_b_reg <= RESET_RESULT;
      end else if (test_capture) begin
         result_a_reg <= sig_a_reg;
         result_b_reg <= sig_b_reg;
      end
   end

   // ---------------------------------------------------------------
   // read-back
   // ---------------------------------------------------------------
   always_comb begin
      read_data = RESET_BYTE;
      case ({shift_in_reg[3:0], pin_sync_reg[3]})
         OFS_DATA_CTRL:  read_data = {data_format, 7'h00};
         OFS_POWER_DOWN: read_data = power_down;
         OFS_MIX_MODE:   read_data = mix_mode;
         OFS_AUX1_LOW:   read_data = aux1_low_reg;
         OFS_AUX1_HIGH:  read_data = aux1_high_reg;
         OFS_SCALE_LOW:  read_data = scale_low_reg;
         OFS_SCALE_HIGH: read_data = scale_high_reg;
         OFS_AUX2_LOW:   read_data = aux2_low_reg;
         OFS_AUX2_HIGH:  read_data = aux2_high_reg;
         OFS_TEST_CTRL:  read_data = test_ctrl_reg;
         OFS_RES_A_LOW:  read_data = result_a_reg[7:0];
         OFS_RES_A_HIGH: read_data = result_a_reg[15:8];
         OFS_RES_B_LOW:  read_data = result_b_reg[7:0];
         OFS_RES_B_HIGH: read_data = result_b_reg[15:8];
         OFS_CHIP_ID:    read_data = {CHIP_VERSION, CHIP_DEVICE};
         default:        read_data = RESET_BYTE;
      endcase
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // words pass unscaled: the current stage is linear in the code
   assign aux_current_word_one = '{pin_select:  aux1_high_reg[PIN_SELECT_BIT],
                                   sink_select: aux1_high_reg[SINK_SELECT_BIT],
                                   word: {aux1_high_reg[1:0], aux1_low_reg}};
   assign aux_current_word_two = '{pin_select:  aux2_high_reg[PIN_SELECT_BIT],
                                   sink_select: aux2_high_reg[SINK_SELECT_BIT],
                                   word: {aux2_high_reg[1:0], aux2_low_reg}};
   assign second_converter_scale_word = {scale_high_reg[1:0], scale_low_reg};
   assign self_test_run = test_ctrl_reg[RUN_BIT];

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         aux_one_positive_out <= 1'b0;
         aux_one_negative_out <= 1'b0;
         aux_two_positive_out <= 1'b0;
         aux_two_negative_out <= 1'b0;
      end else begin
         aux_one_positive_out <= ~aux1_high_reg[PIN_SELECT_BIT];
         aux_one_negative_out <= aux1_high_reg[PIN_SELECT_BIT];
         aux_two_positive_out <= ~aux2_high_reg[PIN_SELECT_BIT];
         aux_two_negative_out <= aux2_high_reg[PIN_SELECT_BIT];
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_aux1_low_write: assert property (
      wr_en_reg && wr_addr == OFS_AUX1_LOW && !pin_sync_reg[0]
      |=> aux_current_word_one.word[7:0] == $past(wr_data_reg))
      else $error("first aux low byte not stored");
   a_aux1_pin_sel: assert property (
      (wr_en_reg && wr_addr == OFS_AUX1_HIGH && !pin_sync_reg[0])
      ##1 !pin_sync_reg[0]
      |=> aux_one_negative_out == $past(wr_data_reg[7], 2)
          && aux_one_positive_out != aux_one_negative_out)
      else $error("first aux pin select wrong");
   a_aux1_sink: assert property (
      wr_en_reg && wr_addr == OFS_AUX1_HIGH && !pin_sync_reg[0]
      |=> aux_current_word_one.sink_select == $past(wr_data_reg[6]))
      else $error("first aux direction wrong");
   a_scale_word: assert property (
      wr_en_reg && wr_addr == OFS_SCALE_HIGH && !pin_sync_reg[0]
      |=> second_converter_scale_word[9:8] == $past(wr_data_reg[1:0]))
      else $error("scale upper bits wrong");
   a_aux2_sink: assert property (
      wr_en_reg && wr_addr == OFS_AUX2_HIGH && !pin_sync_reg[0]
      |=> aux_current_word_two.sink_select == $past(wr_data_reg[6])
          && aux_current_word_two.pin_select == $past(wr_data_reg[7]))
      else $error("second aux control bits wrong");
   a_test_clear: assert property (
      test_clear |=> result_a_reg == RESET_RESULT
                     && result_b_reg == RESET_RESULT
                     && sig_a_reg == RESET_RESULT)
      else $error("self-test clear did not clear");
   a_test_capture: assert property (
      test_capture && !test_clear && !pin_sync_reg[0]
      |=> result_a_reg == $past(sig_a_reg)
          && result_b_reg == $past(sig_b_reg))
      else $error("self-test capture missed");
   a_pin_mix: assert property (
      pin_sync_reg[0]
      |=> mix_mode == ($past(pin_sync_reg[2]) ? PIN_MIX_VALUE : RESET_BYTE))
      else $error("pin mode mix value wrong");
   a_pin_power: assert property (
      pin_sync_reg[0]
      |=> power_down == ($past(pin_sync_reg[4]) ? PIN_POWER_VALUE
                                                : RESET_BYTE))
      else $error("pin mode power-down value wrong");
   a_pin_format: assert property (
      pin_sync_reg[0] |=> data_format == $past(pin_sync_reg[3]))
      else $error("pin mode format bit wrong");
   a_pin_defaults: assert property (
      pin_sync_reg[0] |=> aux_current_word_one.word == RESET_WORD
                          && test_ctrl_reg == RESET_BYTE)
      else $error("reset pin did not restore defaults");
   a_serial_ignored: assert property (
      pin_mode && $past(pin_mode) |-> !wr_en_reg && !serial_data_out_oe)
      else $error("serial port active in pin mode");

   c_aux_write: cover property (wr_en_reg && wr_addr == OFS_AUX1_HIGH);
   c_capture:   cover property (test_capture && result_a_reg != 16'h0000);
   c_read_out:  cover property (serial_data_out_oe && sclk_fall);
   c_pin_mix:   cover property (pin_mode && mix_mode == PIN_MIX_VALUE);

endmodule : dab_regs

// ==== verif/dab_host_model.sv ====
// host controller model: serial frames, reset pin and pin-mode levels
`timescale 1ns/1ps
module dab_host_model (
   // clock and returned data pin
   input  wire logic       sys_clk,
   input  wire logic       sdo_pin,
   // device pins
   output logic            reset_pin,
   output logic            spi_clk,
   output logic            chip_select_low,
   output logic            serial_data_in,
   output logic            sdo_drv,
   // read result
   output logic            rd_done,
   output logic [7:0]      rd_data
);
   // power-up: reset pin high, chip select idle high
   initial begin
      reset_pin = 1'b1;
      spi_clk = 1'b0;
      chip_select_low = 1'b1;
      serial_data_in = 1'b0;
      sdo_drv = 1'b0;
      rd_done = 1'b0;
      rd_data = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   task automatic pins(input logic rp, cs, di, dout);
      reset_pin = rp;
      chip_select_low = cs;
      serial_data_in = di;
      sdo_drv = dout;
   endtask : pins
   // ---------------------------------------------------------------
   // one 16-bit frame, msb first, spi_clk at sys_clk/16
   // ---------------------------------------------------------------
   task automatic xfer(input logic rd, input logic [4:0] a,
                       input logic [7:0] d);
      logic [15:0] f;
      f = {rd, 2'b00, a, d};
      chip_select_low = 1'b0;
      tick(3);
      for (int i = 15; i >= 0; i--) begin
         serial_data_in = f[i];
         tick(8);
         spi_clk = 1'b1;
         if (i < 8) rd_data[i] = sdo_pin;
         tick(8);
         spi_clk = 1'b0;
      end
      // a released line must not keep showing the last bit
      serial_data_in = ~f[0];
      tick(8);
      chip_select_low = 1'b1;
      rd_done = rd;
      tick(1);
      rd_done = 1'b0;
      tick(4);
   endtask : xfer
endmodule : dab_host_model

// ==== verif/dab_regs_test.sv ====
// testbench for the register slice: registers, self-test and pin mode
`timescale 1ns/1ps
module dab_regs_test;
   import dab_pkg::*;
   logic sys_clk, sys_rst, reset_pin, spi_clk, cs_n, sdi, sdo_drv, sdo_pin;
   logic sdo_out, sdo_oe, rd_done, p1, n1, p2, n2, data_format;
   logic self_test_run, pin_mode;
   logic [7:0] rd_data, mix_mode, power_down;
   logic [9:0] scale;
   logic [15:0] word_a, word_b, res_a, res_b;
   dab_aux_cfg_s aux1, aux2;
   logic [7:0] exp_q[$];
   logic [4:0] adr [6] = '{5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12};
   logic [7:0] msk [6] = '{8'hff, 8'hc3, 8'hff, 8'h03, 8'hff, 8'hc3};
   logic [7:0] val [6];
   int failures = 0, num_checks = 0, cycles = 0;
   assign sdo_pin = sdo_oe ? sdo_out : sdo_drv;
   dab_regs #(.CHIP_VERSION(4'h6), .CHIP_DEVICE(4'h9)) u_dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_pin(reset_pin),
      .spi_clk(spi_clk), .chip_select_low(cs_n), .serial_data_in(sdi),
      .serial_data_out_in(sdo_pin), .serial_data_out(sdo_out),
      .serial_data_out_oe(sdo_oe), .self_test_word_a(word_a),
      .self_test_word_b(word_b), .aux_current_word_one(aux1),
      .aux_current_word_two(aux2), .aux_one_positive_out(p1),
      .aux_one_negative_out(n1), .aux_two_positive_out(p2),
      .aux_two_negative_out(n2), .second_converter_scale_word(scale),
      .data_format(data_format), .mix_mode(mix_mode),
      .power_down(power_down), .self_test_run(self_test_run),
      .pin_mode(pin_mode));
   dab_host_model u_host (.sys_clk(sys_clk), .sdo_pin(sdo_pin),
      .reset_pin(reset_pin), .spi_clk(spi_clk), .chip_select_low(cs_n),
      .serial_data_in(sdi), .sdo_drv(sdo_drv), .rd_done(rd_done),
      .rd_data(rd_data));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      num_checks++;
      if (seen !== want) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic complete_run();
      if (failures == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      u_host.xfer(1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.xfer(1'b1, a, 8'h00);
   endtask : rd
   // ---------------------------------------------------------------
   // read watcher and hang guard
   // ---------------------------------------------------------------
   always @(posedge rd_done) begin
      if (exp_q.size() != 0) check(16'(rd_data), 16'(exp_q.pop_front()));
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      sys_rst = 1'b1;
      void'($urandom(32'h3a62));
      word_a = 16'($urandom());
      word_b = 16'($urandom());
      u_host.tick(10);
      sys_rst = 1'b0;
      u_host.tick(3);
      u_host.pins(1'b0, 1'b1, 1'b0, 1'b0);
      u_host.tick(6);
      wr(5'h0d, 8'h5a);
      for (int k = 0; k < 8; k++) begin
         u_host.pins(1'b1, k[0], k[1], k[2]);
         u_host.tick(6);
         check(16'(pin_mode), 16'h1);
         check(16'(data_format), 16'(k[1]));
         check(16'(mix_mode), k[0] ? 16'h05 : 16'h00);
         check(16'(power_down), k[2] ? 16'hff : 16'h00);
      end
      // a frame in pin mode must not raise a write
      wr(5'h11, 8'ha5);
      u_host.pins(1'b0, 1'b1, 1'b0, 1'b0);
      u_host.tick(6);
      rd(5'h0d, 8'h00);
      rd(5'h15, 8'h00);
      wr(5'h1f, 8'h00);
      rd(5'h1f, 8'h69);
      wr(5'h1b, 8'hff);
      rd(5'h1b, 8'h00);
      repeat (2) begin
         for (int i = 0; i < 6; i++) begin
            val[i] = 8'($urandom());
            wr(adr[i], val[i]);
         end
         for (int i = 0; i < 6; i++) rd(adr[i], val[i] & msk[i]);
         check(16'(aux1), 16'({val[1][7:6], val[1][1:0], val[0]}));
         check(16'(aux2), 16'({val[5][7:6], val[5][1:0], val[4]}));
         check(16'(scale), 16'({val[3][1:0], val[2]}));
         check(16'({p1, n1, p2, n2}),
               16'({~val[1][7], val[1][7], ~val[5][7], val[5][7]}));
      end
      // both engines run on odd random words; results stay zero until copied
      word_a = 16'($urandom()) | 16'h0001;
      word_b = 16'($urandom()) | 16'h0001;
      wr(5'h1a, 8'h80);
      check(16'(self_test_run), 16'h1);
      rd(5'h1b, 8'h00);
      rd(5'h1d, 8'h00);
      rd(5'h1e, 8'h00);
      wr(5'h1a, 8'h40);
      check(16'(self_test_run), 16'h0);
      rd(5'h1a, 8'h40);
      u_host.xfer(1'b1, 5'h1b, 8'h00);
      res_a[7:0] = rd_data;
      u_host.xfer(1'b1, 5'h1c, 8'h00);
      res_a[15:8] = rd_data;
      u_host.xfer(1'b1, 5'h1d, 8'h00);
      res_b[7:0] = rd_data;
      u_host.xfer(1'b1, 5'h1e, 8'h00);
      res_b[15:8] = rd_data;
      check(16'(res_a !== 16'h0000), 16'h1);
      check(16'(res_b !== 16'h0000), 16'h1);
      wr(5'h1a, 8'h20);
      rd(5'h1b, 8'h00);
      rd(5'h1c, 8'h00);
      rd(5'h1d, 8'h00);
      rd(5'h1e, 8'h00);
      u_host.tick(20);
      complete_run();
   end
endmodule : dab_regs_test
